// [hdl/sensor_cmd_pkg.sv]
// Purpose: constants and types for the sensor command unit
// Assumes: core clock of 200 MHz
// Notes: rule summary below
//
// How it works
// - answer only target address 1110110
// - one command byte follows the address
// - reads return 24, 16 or 8 bits
// - codes a0..ae pick calibration word
// - reset code 1e reloads calibration words
// - reset command accepted in any state
// - seven 16-bit calibration words held
// - calibration word sent msb first
// - word read needs write then read
// - codes 40..4a and 50..5a start conversions
// - result read shifts out msb first
// - missing or repeated result reads zero
// - read during conversion gives zero, corrupts
// - conversion during conversion corrupts result
// - busy until conversion done, then valid
// - read bytes wait for controller acknowledge
// - results are unsigned 24-bit values

package sensor_cmd_pkg;

    // ------------------------------------------------------------
    // codes and sizes
    // ------------------------------------------------------------
    localparam logic [6:0] target_addr = 7'h76;
    localparam logic [7:0] cmd_reset = 8'h1e;
    localparam logic [7:0] cmd_adc_read = 8'h00;
    localparam logic [3:0] prom_nibble = 4'ha;
    localparam logic [3:0] press_nibble = 4'h4;
    localparam logic [3:0] temp_nibble = 4'h5;
    localparam logic [2:0] osr_max = 3'h5;
    localparam logic [2:0] prom_missing_idx = 3'h7;
    localparam int cal_words = 7;
    localparam int word_width = 16;
    localparam logic [3:0] byte_bits = 4'h8;
    localparam logic [1:0] adc_bytes = 2'h3;
    localparam logic [1:0] prom_bytes = 2'h2;
    localparam logic [1:0] idle_bytes = 2'h1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int clk_period_ns = 5;
    localparam int unsigned convert_flag_time_us [6] = '{560, 1100, 2170, 4320, 8610, 17200};

    function automatic int unsigned convert_flag_cycles_of(input int idx);
        return convert_flag_time_us[idx] * 1000 / clk_period_ns;
    endfunction : convert_flag_cycles_of

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic conversion_kind_bit;
        logic [2:0] oversampling_ratio;
    } convert_flag_job_type;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_addr = 3'h1,
        st_addr_ack = 3'h3,
        st_wr = 3'h2,
        st_wr_ack = 3'h6,
        st_rd = 3'h7,
        st_rd_ack = 3'h5
    } link_state_type;

    function automatic logic is_convert_flag(input logic [7:0] c);
        return (c[7:4] == press_nibble || c[7:4] == temp_nibble) && !c[0] && c[3:1] <= osr_max;
    endfunction : is_convert_flag

    function automatic logic is_prom(input logic [7:0] c);
        return c[7:4] == prom_nibble && !c[0];
    endfunction : is_prom

    function automatic logic is_known(input logic [7:0] c);
        return is_convert_flag(c) || is_prom(c) || c == cmd_reset || c == cmd_adc_read;
    endfunction : is_known

endpackage : sensor_cmd_pkg

// [hdl/pressure_sensor_i2c_command_unit.sv]
// Purpose: i2c target command side of a pressure sensor
// Assumes: scl and sda arrive asynchronously, sampled on core_clk
// Notes: sda is open drain, sda_out stays low, sda_oe pulls

`timescale 1ns/100ps
`default_nettype none

module pressure_sensor_i2c_command_unit
    import sensor_cmd_pkg::*;
#(
    parameter int unsigned convert_flag_cycles [6] = '{convert_flag_cycles_of(0), convert_flag_cycles_of(1),
        convert_flag_cycles_of(2), convert_flag_cycles_of(3), convert_flag_cycles_of(4), convert_flag_cycles_of(5)}
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [cal_words*word_width-1:0] cal_image,
    input wire logic [23:0] raw_pressure_sample,
    input wire logic [23:0] raw_temperature_sample,
    output logic busy,
    output convert_flag_job_type convert_flag_job,
    output logic result_valid
);

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic sda_s;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta <= 2'h3;
            pin_sync <= 2'h3;
            pin_prev <= 2'h3;
        end else begin
            pin_meta <= {scl_in, sda_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign sda_s = pin_sync[0];
    assign scl_rise = pin_sync[1] & ~pin_prev[1];
    assign scl_fall = ~pin_sync[1] & pin_prev[1];
    // framing: data moves while the clock is high
    assign start_cond = pin_sync[1] & pin_prev[1] & pin_prev[0] & ~sda_s;
    assign stop_cond = pin_sync[1] & pin_prev[1] & ~pin_prev[0] & sda_s;

    // ------------------------------------------------------------
    // link state machine
    // ------------------------------------------------------------
    link_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] rx;
    logic [23:0] tx;
    logic [1:0] bytes_left;
    logic master_ack;
    logic first_byte;
    logic cmd_strobe;
    logic [23:0] read_word;
    logic [1:0] read_bytes;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= st_idle;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 24'h0;
            bytes_left <= 2'h0;
            master_ack <= 1'b0;
            first_byte <= 1'b0;
            cmd_strobe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            cmd_strobe <= 1'b0;
            if (start_cond) begin
                state <= st_addr;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state <= st_idle;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    st_idle: begin
                        sda_oe <= 1'b0;
                    end
                    st_addr, st_wr: begin
                        if (scl_rise) begin
                            rx <= {rx[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == byte_bits) begin
                            bit_cnt <= 4'h0;
                            if (state == st_wr) begin
                                // only the first byte is a command
                                sda_oe <= 1'b1;
                                state <= st_wr_ack;
                                cmd_strobe <= first_byte;
                                first_byte <= 1'b0;
                            end else if (rx[7:1] == target_addr) begin
                                sda_oe <= 1'b1;
                                state <= st_addr_ack;
                            end else begin
                                state <= st_idle;
                            end
                        end
                    end
                    st_addr_ack: begin
                        if (scl_fall) begin
                            if (rx[0]) begin
                                state <= st_rd;
                                tx <= read_word;
                                bytes_left <= read_bytes - 2'h1;
                                sda_oe <= ~read_word[23];
                            end else begin
                                state <= st_wr;
                                sda_oe <= 1'b0;
                                first_byte <= 1'b1;
                            end
                        end
                    end
                    st_wr_ack: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= st_wr;
                        end
                    end
                    st_rd: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            // msb first shift
                            tx <= {tx[22:0], 1'b0};
                            if (bit_cnt == byte_bits) begin
                                bit_cnt <= 4'h0;
                                sda_oe <= 1'b0;
                                state <= st_rd_ack;
                            end else begin
                                sda_oe <= ~tx[22];
                            end
                        end
                    end
                    st_rd_ack: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_s;
                        end else if (scl_fall) begin
                            // next byte only after an acknowledge
                            if (master_ack && bytes_left != 2'h0) begin
                                state <= st_rd;
                                bytes_left <= bytes_left - 2'h1;
                                sda_oe <= ~tx[23];
                            end else begin
                                state <= st_idle;
                            end
                        end
                    end
                    default: begin
                        state <= st_idle;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // calibration words
    // ------------------------------------------------------------
    logic [word_width-1:0] cal_reg [cal_words];
    logic cmd_is_reset;
    logic cmd_is_adc;

    assign cmd_is_reset = cmd_strobe && rx == cmd_reset;
    assign cmd_is_adc = cmd_strobe && rx == cmd_adc_read;

    genvar gi;
    generate
        for (gi = 0; gi < cal_words; gi++) begin : g_cal
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    cal_reg[gi] <= 16'h0;
                end else if (cmd_is_reset) begin
                    cal_reg[gi] <= cal_image[gi*word_width +: word_width];
                end
            end
        end
    endgenerate

    // word index 7 has no storage and reads as zero
    function automatic logic [15:0] cal_word(input logic [2:0] idx);
        return (idx == prom_missing_idx) ? 16'h0 : cal_reg[idx];
    endfunction : cal_word

    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    logic [21:0] convert_flag_count;
    logic corrupt;
    logic [23:0] result;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy <= 1'b0;
            convert_flag_count <= 22'h0;
            convert_flag_job <= '0;
            corrupt <= 1'b0;
            result <= 24'h0;
            result_valid <= 1'b0;
        end else if (cmd_is_reset) begin
            busy <= 1'b0;
            convert_flag_count <= 22'h0;
            corrupt <= 1'b0;
            result <= 24'h0;
            result_valid <= 1'b0;
        end else if (cmd_strobe && is_convert_flag(rx)) begin
            corrupt <= busy; // overlap spoils the value
            busy <= 1'b1;
            convert_flag_job <= '{rx[4], rx[3:1]};
            convert_flag_count <= 22'(convert_flag_cycles[rx[3:1]]);
            result_valid <= 1'b0;
        end else if (cmd_is_adc) begin
            result_valid <= 1'b0; // a second read sees zero
            corrupt <= corrupt | busy; // conversion runs on
        end else if (busy) begin
            if (convert_flag_count == 22'h1) begin
                busy <= 1'b0;
                result_valid <= 1'b1;
                // unsigned raw sample, bits flipped when spoiled
                result <= (convert_flag_job.conversion_kind_bit ? raw_temperature_sample
                           : raw_pressure_sample) ^ {24{corrupt}};
                corrupt <= 1'b0;
            end else begin
                convert_flag_count <= convert_flag_count - 22'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            read_word <= 24'h0;
            read_bytes <= idle_bytes;
        end else if (cmd_is_reset) begin
            read_word <= 24'h0;
            read_bytes <= idle_bytes;
        end else if (cmd_is_adc) begin
            read_word <= (result_valid && !busy) ? result : 24'h0;
            read_bytes <= adc_bytes;
        end else if (cmd_strobe && is_prom(rx)) begin
            read_word <= {cal_word(rx[3:1]), 8'h00};
            read_bytes <= prom_bytes;
        end
        // other bytes leave everything alone
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_cmd(logic [7:0] c);
        cmd_strobe && rx == c;
    endsequence

    sequence s_convert_flag;
        cmd_strobe && is_convert_flag(rx);
    endsequence

    chk_addr_miss: assert property (@(posedge core_clk) disable iff (rst)
        state == st_addr && scl_fall && bit_cnt == byte_bits && !start_cond && !stop_cond
        && rx[7:1] != target_addr |=> state == st_idle && !sda_oe)
        else $error("foreign address was answered");

    chk_prom_pick: assert property (@(posedge core_clk) disable iff (rst)
        cmd_strobe && is_prom(rx) && rx[3:1] != prom_missing_idx
        |=> read_word[23:8] == cal_reg[$past(rx[3:1])] && read_bytes == prom_bytes)
        else $error("wrong calibration word selected");

    chk_reset_any: assert property (@(posedge core_clk) disable iff (rst)
        s_cmd(cmd_reset) |=> !busy && !result_valid && read_word == 24'h0)
        else $error("reset command left state behind");

    chk_convert_flag_load: assert property (@(posedge core_clk) disable iff (rst)
        s_convert_flag |=> busy && convert_flag_job.oversampling_ratio == $past(rx[3:1]))
        else $error("conversion not started");

    chk_adc_none: assert property (@(posedge core_clk) disable iff (rst)
        s_cmd(cmd_adc_read) ##0 !result_valid |=> read_word == 24'h0 && !result_valid)
        else $error("stale result returned");

    chk_adc_busy: assert property (@(posedge core_clk) disable iff (rst)
        s_cmd(cmd_adc_read) ##0 busy |=> read_word == 24'h0 && corrupt && busy)
        else $error("read during conversion mishandled");

    chk_convert_flag_clash: assert property (@(posedge core_clk) disable iff (rst)
        s_convert_flag ##0 busy |=> corrupt)
        else $error("overlapping conversion not marked");

    chk_convert_flag_done: assert property (@(posedge core_clk) disable iff (rst)
        busy && convert_flag_count == 22'h1 && !cmd_strobe
        |=> !busy && result_valid ##1 (!busy || $past(cmd_strobe)))
        else $error("conversion end not reported");

    chk_busy_hold: assert property (@(posedge core_clk) disable iff (rst)
        busy && convert_flag_count > 22'h1 && !cmd_strobe |=> busy && !result_valid)
        else $error("busy dropped early");

    chk_rd_release: assert property (@(posedge core_clk) disable iff (rst)
        state == st_rd_ack |-> !sda_oe)
        else $error("data line held in acknowledge slot");

    chk_bad_cmd: assert property (@(posedge core_clk) disable iff (rst)
        cmd_strobe && !is_known(rx) |=> $stable(read_word)
        && ($stable(result) || $past(busy && convert_flag_count == 22'h1)))
        else $error("unknown command changed state");

endmodule : pressure_sensor_i2c_command_unit

`default_nettype wire

// [verification/i2c_host_model.sv]
// Purpose: i2c controller stand-in for the sensor command unit
// Assumes: 48 ns scl period, sda wire has a pull-up
// Notes: scl stands high between frames; sda is pulled low or released
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
    output logic scl,
    output logic pull,
    input wire logic sda,
    output logic [7:0] seen_val,
    output logic seen_stb
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
        seen_val = 8'h00;
        seen_stb = 1'b0;
    end
    // ----
    // bit level
    // ----
    // data moves 18 ns after the fall so the device has let go first
    task automatic bit_io(input logic b, output logic r);
        #18 pull = !b;
        #6 scl = 1'b1;
        #20 r = sda;
        #4 scl = 1'b0;
    endtask : bit_io
    task automatic note(input logic [7:0] v);
        seen_val = v;
        seen_stb = 1'b1;
        #1 seen_stb = 1'b0;
    endtask : note
    // every message is framed by start and stop
    task automatic frame_open();
        #24 pull = 1'b1;
        #24 scl = 1'b0;
    endtask : frame_open
    task automatic frame_close();
        #18 pull = 1'b1;
        #6 scl = 1'b1;
        #24 pull = 1'b0;
        #48;
    endtask : frame_close
    // free a held data line with spare clocks
    task automatic recover();
        repeat (9) begin
            #24 scl = 1'b0;
            #24 scl = 1'b1;
        end
    endtask : recover
    task automatic wr_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        note({7'h00, r});
    endtask : wr_byte
    // ack each byte but the last, nack that one
    task automatic rd_byte(input logic last);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(last, r);
        note(v);
    endtask : rd_byte
endmodule : i2c_host_model
`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench for the sensor command unit
// Assumes: 200 MHz core clock, short conversion counts
// Notes: bytes seen on the bus are checked against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sensor_cmd_pkg::*;
    // short counts keep the run small; each must outlast a command frame and stay under the 1200-tick wait
    localparam int unsigned cyc [6] = '{300, 340, 380, 420, 460, 500};
    logic core_clk, rst, scl, pull, sda_out, sda_oe, busy, result_valid, seen_stb;
    wire logic sda;
    logic [7:0] seen_val;
    logic [111:0] cal_image;
    logic [23:0] p_raw, t_raw;
    convert_flag_job_type convert_flag_job;
    logic [7:0] expq [$];
    int n_fail, checked;
    logic [31:0] seed;
    assign sda = !(sda_oe | pull);
    pressure_sensor_i2c_command_unit #(.convert_flag_cycles(cyc)) i_pressure_sensor_i2c_command_unit (
        .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .cal_image(cal_image), .raw_pressure_sample(p_raw),
        .raw_temperature_sample(t_raw), .busy(busy), .convert_flag_job(convert_flag_job),
        .result_valid(result_valid));
    i2c_host_model i_i2c_host_model (.scl(scl), .pull(pull), .sda(sda), .seen_val(seen_val),
        .seen_stb(seen_stb));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = !core_clk;
    end
    // ----
    // helpers
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // fractional offset keeps every host pin change off a core clock edge
    task automatic tick();
        @(posedge core_clk);
        #1.2;
    endtask : tick
    task automatic fail(input string msg);
        $display("wrong value at %0t: %s", $time, msg);
        n_fail++;
    endtask : fail
    task automatic expect_eq(input logic [23:0] got, input logic [23:0] exp, input string msg);
        checked++;
        if (got !== exp) fail(msg);
    endtask : expect_eq
    task automatic cmd(input logic [7:0] c);
        expq.push_back(8'h00);
        expq.push_back(8'h00);
        i_i2c_host_model.frame_open();
        i_i2c_host_model.wr_byte({target_addr, 1'b0});
        i_i2c_host_model.wr_byte(c);
        i_i2c_host_model.frame_close();
    endtask : cmd
    task automatic rd(input int n, input logic [23:0] exp);
        expq.push_back(8'h00);
        for (int i = 0; i < n; i++) expq.push_back(8'(exp >> (8 * (n - 1 - i))));
        i_i2c_host_model.frame_open();
        i_i2c_host_model.wr_byte({target_addr, 1'b1});
        for (int i = 0; i < n; i++) i_i2c_host_model.rd_byte(i == n - 1);
        i_i2c_host_model.frame_close();
    endtask : rd
    task automatic wait_valid();
        for (int i = 0; i < 1200 && result_valid !== 1'b1; i++) tick();
        expect_eq(result_valid, 1, "conversion never finished");
    endtask : wait_valid
    task automatic summarize();
        if (expq.size() != 0) fail("notes left with no byte seen");
        $display("counts: checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    always @(posedge seen_stb) begin : watch
        logic [7:0] e;
        checked++;
        if (expq.size() == 0) begin
            fail("byte with no note");
        end else begin
            e = expq.pop_front();
            if (seen_val !== e) fail("bus byte");
        end
    end
    initial begin
        #400000;
        fail("watchdog");
        summarize();
    end
    // ----
    // tests
    // ----
    initial begin
        seed = 32'h8cc8;
        rst = 1'b1;
        n_fail = 0;
        checked = 0;
        cal_image = 112'({rnd(), rnd(), rnd(), rnd()});
        p_raw = 24'(rnd());
        t_raw = 24'(rnd());
        repeat (5) tick();
        rst = 1'b0;
        repeat (3) tick();
        rd(1, 0);
        expq.push_back(8'h01);
        i_i2c_host_model.frame_open();
        i_i2c_host_model.wr_byte({7'h77, 1'b0});
        i_i2c_host_model.frame_close();
        $display("test idle and address done");
        i_i2c_host_model.recover();
        cmd({prom_nibble, 3'h1, 1'b0});
        rd(2, 0);
        cmd(cmd_reset);
        for (int i = 0; i < 8; i++) begin
            cmd({prom_nibble, 3'(i), 1'b0});
            rd(2, (i < cal_words) ? 24'(cal_image[16*i +: 16]) : 24'h0);
        end
        $display("test calibration words done");
        for (int k = 0; k < 12; k++) begin
            tick();
            p_raw = 24'(rnd());
            t_raw = 24'(rnd());
            cmd({(k < 6) ? press_nibble : temp_nibble, 3'(k % 6), 1'b0});
            expect_eq(busy, 1, "busy after start");
            expect_eq({20'h0, convert_flag_job}, {20'h0, k >= 6, 3'(k % 6)}, "job");
            expect_eq(result_valid, 0, "valid while busy");
            wait_valid();
            cmd({(k < 6) ? press_nibble : temp_nibble, 3'(k % 6), 1'b1});
            expect_eq(busy, 0, "odd code started work");
            cmd(cmd_adc_read);
            rd(3, (k < 6) ? p_raw : t_raw);
            cmd(cmd_adc_read);
            rd(3, 0);
        end
        $display("test conversions done");
        cmd(8'h44);
        cmd(cmd_adc_read);
        rd(3, 0);
        wait_valid();
        cmd(cmd_adc_read);
        rd(3, ~p_raw);
        cmd(8'h50);
        cmd(8'h52);
        wait_valid();
        cmd(cmd_adc_read);
        rd(3, ~t_raw);
        $display("test misordered reads done");
        cmd(8'h5a);
        cmd(cmd_reset);
        expect_eq(busy, 0, "busy after reset");
        expect_eq(result_valid, 0, "valid after reset");
        expect_eq(sda_out, 0, "data drive level");
        rd(1, 0);
        $display("test reset in conversion done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
